// file: core/igc_defines.svh
// Constants of the ignition gate control block: offsets, fields, resets, timing.
// Assumes a 200 MHz mclk; included by bare name from the top and the bench.
`ifndef IGC_DEFINES_SVH
`define IGC_DEFINES_SVH

`define IGC_CLK_MHZ 200
`define IGC_REG_SPARK 4'h0
`define IGC_REG_DAC 4'h4
`define IGC_REG_MODE 4'h8
`define IGC_REG_STATUS 4'hC

`define IGC_SPARK_RESET 12'h90D
`define IGC_DAC_RESET 8'h80
`define IGC_MODE_RESET 2'h0

`define IGC_B_END_LO 0
`define IGC_B_OS_LO 2
`define IGC_B_CLAMP_EN 4
`define IGC_B_GENTLE 5
`define IGC_B_GAIN 6
`define IGC_B_DWELL_EN 8
`define IGC_B_DWELL_LO 9
`define IGC_B_OVL_LO 5
`define IGC_B_GENERAL 0
`define IGC_B_OVL_EN 1

`define IGC_OS_10_US 10
`define IGC_OS_20_US 20
`define IGC_OS_50_US 50
`define IGC_OS_100_US 100
`define IGC_US_CYC(t) ((t) * `IGC_CLK_MHZ)
`define IGC_MS_CYC(t) ((t) * 1000 * `IGC_CLK_MHZ)
`define IGC_DWELL_2_MS 2
`define IGC_DWELL_4_MS 4
`define IGC_DWELL_8_MS 8
`define IGC_DWELL_16_MS 16
`define IGC_DWELL_32_MS 32
`define IGC_DWELL_64_MS 64

`endif

// file: core/igc_pkg.sv
// Types of the ignition gate control block.
// Constants live in igc_defines.svh.
package igc_pkg;
  typedef logic [23:0] igc_count_t;

  typedef struct packed {
    logic [11:0] spark_q;
    logic [7:0] dac_q;
    logic [1:0] mode_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic gate_prev_q;
    logic gate_on_q;
    logic off_latched_q;
    logic os_fault_q;
    logic dwell_fault_q;
    logic soft_q;
    logic clamp_q;
    logic spark_len_q;
    logic [6:0] offset_pct_q;
  } igc_top_s;

  typedef struct packed {
    igc_count_t count_q;
    logic expired_q;
  } igc_timer_s;
endpackage : igc_pkg

// file: core/igc_sync.sv
// Two-flop synchroniser for a vector of independent pin levels.
// Each bit is a slow level; no bus coherence is implied.
`timescale 1ns/1ps
module igc_sync #(
  parameter int W = 1
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [W-1:0] async_in, // Pin levels
  output logic [W-1:0] sync_out // Levels in the mclk domain
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;
endmodule : igc_sync

// file: core/igc_timer.sv
// Saturating interval timer: counts while run, clears on clr.
// expired rises once the count has reached limit while running.
`timescale 1ns/1ps
module igc_timer
  import igc_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clr, // Clear count and expiry
  input wire logic run, // Count this cycle
  input wire igc_count_t limit, // Interval in cycles
  output logic expired // Interval passed, level
);
  igc_timer_s st_q;
  igc_timer_s st_d;

  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.count_q = '0;
      st_d.expired_q = 1'b0;
    end else if (run) begin
      if (st_q.count_q >= limit) begin
        st_d.expired_q = 1'b1;
      end else begin
        st_d.count_q = st_q.count_q + 24'h000001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expired = st_q.expired_q;
endmodule : igc_timer

// file: core/igc_top.sv
// Ignition control logic of one gate pre-driver channel, Avalon-MM slave.
// Assumes analog comparators outside: begin-spark, end-spark and 135 V primary.
`timescale 1ns/1ps
`include "igc_defines.svh"
module igc_top
  import igc_pkg::*;
#(
  parameter igc_count_t OS_50_CYC = 24'(`IGC_US_CYC(`IGC_OS_50_US)),
  parameter igc_count_t OS_100_CYC = 24'(`IGC_US_CYC(`IGC_OS_100_US)),
  parameter igc_count_t DWELL_2_CYC = 24'(`IGC_MS_CYC(`IGC_DWELL_2_MS)),
  parameter igc_count_t DWELL_4_CYC = 24'(`IGC_MS_CYC(`IGC_DWELL_4_MS)),
  parameter igc_count_t DWELL_8_CYC = 24'(`IGC_MS_CYC(`IGC_DWELL_8_MS)),
  parameter igc_count_t DWELL_16_CYC = 24'(`IGC_MS_CYC(`IGC_DWELL_16_MS)),
  parameter igc_count_t DWELL_32_CYC = 24'(`IGC_MS_CYC(`IGC_DWELL_32_MS)),
  parameter igc_count_t DWELL_64_CYC = 24'(`IGC_MS_CYC(`IGC_DWELL_64_MS))
) (
  input wire logic mclk, // System clock, 200 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Byte lanes of a write
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic gate_control_in, // Gate input pin from the controller
  input wire logic outputs_off_in, // Output disable pin, high disables
  input wire logic overvoltage_in, // Supply overvoltage comparator
  input wire logic collector_feedback_hi_in, // Feedback above supply plus 21 V
  input wire logic collector_feedback_lo_in, // Feedback below end-spark threshold
  input wire logic primary_high_in, // Primary above 135 V
  input wire logic other_dwell_in, // Another ignition driver is on
  output logic gate_drive_out, // Gate drive command
  output logic low_clamp_out, // Low-voltage clamp active
  output logic spark_length_out, // Spark length level to controller
  output logic [1:0] end_spark_sel_out, // End-spark threshold code to comparator
  output logic gain_two_out, // Current amplifier gain two
  output logic [6:0] max_current_offset_out // Max current threshold raise, percent
);
  localparam int NSYNC = 7;

  igc_top_s st_q;
  igc_top_s st_d;
  logic [NSYNC-1:0] pins;
  logic gate_lvl;
  logic off_lvl;
  logic ov_lvl;
  logic fb_hi;
  logic fb_lo;
  logic prim_hi;
  logic other_on;
  logic ign;
  logic gate_rise;
  logic req;
  logic os_exp;
  logic dwell_exp;
  logic dwell_trip;
  logic dwell_en;
  logic gentle_en;
  logic clamp_en;
  logic dwell_fault_vis;
  igc_count_t os_limit;
  igc_count_t dwell_limit;
  logic [31:0] wr_old;
  logic [31:0] wr_word;

  // Percent raise of the max current threshold for a compensation code
  function automatic logic [6:0] overlap_pct(input logic [2:0] code);
    case (code)
      3'h0: overlap_pct = 7'h00;
      3'h1: overlap_pct = 7'h07;
      3'h2: overlap_pct = 7'h0F;
      3'h3: overlap_pct = 7'h18;
      3'h4: overlap_pct = 7'h23;
      3'h5: overlap_pct = 7'h2F;
      3'h6: overlap_pct = 7'h3F;
      default: overlap_pct = 7'h50;
    endcase
  endfunction : overlap_pct

  // Merge one write into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wdata,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    be_merge = res;
  endfunction : be_merge

  igc_sync #(
    .W(NSYNC)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({other_dwell_in, primary_high_in, collector_feedback_lo_in,
               collector_feedback_hi_in, overvoltage_in, outputs_off_in,
               gate_control_in}),
    .sync_out(pins)
  );

  assign gate_lvl = pins[0];
  assign off_lvl = pins[1];
  assign ov_lvl = pins[2];
  assign fb_hi = pins[3];
  assign fb_lo = pins[4];
  assign prim_hi = pins[5];
  assign other_on = pins[6];

  assign ign = !st_q.mode_q[`IGC_B_GENERAL];
  assign gate_rise = gate_lvl && !st_q.gate_prev_q;
  assign dwell_en = st_q.spark_q[`IGC_B_DWELL_EN];
  assign gentle_en = st_q.spark_q[`IGC_B_GENTLE];
  assign clamp_en = st_q.spark_q[`IGC_B_CLAMP_EN];

  always_comb begin
    case (st_q.spark_q[`IGC_B_OS_LO +: 2])
      2'h0: os_limit = 24'(`IGC_US_CYC(`IGC_OS_10_US));
      2'h1: os_limit = 24'(`IGC_US_CYC(`IGC_OS_20_US));
      2'h2: os_limit = OS_50_CYC;
      default: os_limit = OS_100_CYC;
    endcase
  end

  always_comb begin
    case (st_q.spark_q[`IGC_B_DWELL_LO +: 3])
      3'h0: dwell_limit = DWELL_2_CYC;
      3'h1: dwell_limit = DWELL_4_CYC;
      3'h2: dwell_limit = DWELL_8_CYC;
      3'h3: dwell_limit = DWELL_16_CYC;
      3'h4: dwell_limit = DWELL_32_CYC;
      default: dwell_limit = DWELL_64_CYC;
    endcase
  end

  // Addressed register widened to a bus word, base of the byte merge
  always_comb begin
    case (avs_address)
      `IGC_REG_SPARK: wr_old = {20'h00000, st_q.spark_q};
      `IGC_REG_DAC: wr_old = {24'h000000, st_q.dac_q};
      `IGC_REG_MODE: wr_old = {30'h00000000, st_q.mode_q};
      default: wr_old = 32'h00000000;
    endcase
  end

  assign wr_word = be_merge(wr_old, avs_writedata, avs_byteenable);

  // Open-secondary timer: runs above 135 V, clears on the fall or a new dwell
  igc_timer u_os_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .clr(!prim_hi || gate_rise),
    .run(prim_hi && ign),
    .limit(os_limit),
    .expired(os_exp)
  );

  // Dwell timer: runs while the gate is driven, clears with the gate input low
  igc_timer u_dwell_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .clr(!gate_lvl),
    .run(ign && st_q.gate_on_q),
    .limit(dwell_limit),
    .expired(dwell_exp)
  );

  assign dwell_trip = ign && dwell_en && dwell_exp;
  assign dwell_fault_vis = st_q.dwell_fault_q && dwell_en;
  assign req = avs_read || avs_write;

  always_comb begin
    st_d = st_q;
    st_d.gate_prev_q = gate_lvl;
    // One wait cycle per access; the answer stands in the ack cycle
    st_d.ack_q = req && !st_q.ack_q;
    if (avs_read && !st_q.ack_q) begin
      case (avs_address)
        `IGC_REG_SPARK: st_d.rdata_q = {20'h00000, st_q.spark_q};
        `IGC_REG_DAC: st_d.rdata_q = {24'h000000, st_q.dac_q};
        `IGC_REG_MODE: st_d.rdata_q = {30'h00000000, st_q.mode_q};
        `IGC_REG_STATUS: st_d.rdata_q = {26'h0000000, dwell_fault_vis, st_q.os_fault_q,
                                         st_q.clamp_q, st_q.spark_len_q,
                                         st_q.gate_on_q, gate_lvl};
        default: st_d.rdata_q = 32'h00000000;
      endcase
    end
    if (avs_write && st_q.ack_q) begin
      case (avs_address)
        `IGC_REG_SPARK: st_d.spark_q = wr_word[11:0];
        `IGC_REG_DAC: st_d.dac_q = wr_word[7:0];
        `IGC_REG_MODE: st_d.mode_q = wr_word[1:0];
        default: st_d.mode_q = st_q.mode_q;
      endcase
    end

    // Shutdown latches release with the gate input low or in general mode
    if (!gate_lvl) begin
      st_d.off_latched_q = 1'b0;
      st_d.soft_q = 1'b0;
    end
    if (gate_rise) begin
      st_d.os_fault_q = 1'b0;
      st_d.dwell_fault_q = 1'b0;
    end
    if (dwell_trip) begin
      st_d.off_latched_q = 1'b1;
      st_d.dwell_fault_q = 1'b1;
    end
    if (ign && gentle_en && st_q.gate_on_q && (off_lvl || ov_lvl)) begin
      st_d.soft_q = 1'b1;
    end
    if (ign && os_exp) begin
      st_d.os_fault_q = 1'b1;
    end
    if (!ign) begin
      st_d.os_fault_q = 1'b0;
      st_d.dwell_fault_q = 1'b0;
      st_d.soft_q = 1'b0;
      st_d.off_latched_q = 1'b0;
    end

    st_d.gate_on_q = gate_lvl && !st_d.off_latched_q && !off_lvl && !ov_lvl;
    st_d.clamp_q = ign && ((st_d.dwell_fault_q && dwell_en && gentle_en)
                   || st_d.soft_q
                   || (st_d.os_fault_q && clamp_en));

    if (!ign) begin
      st_d.spark_len_q = 1'b0;
    end else if (fb_hi) begin
      st_d.spark_len_q = 1'b1;
    end else if (fb_lo) begin
      st_d.spark_len_q = 1'b0;
    end

    if (ign && st_q.mode_q[`IGC_B_OVL_EN]
        && other_on && st_q.gate_on_q) begin
      st_d.offset_pct_q = overlap_pct(st_q.dac_q[`IGC_B_OVL_LO +: 3]);
    end else begin
      st_d.offset_pct_q = 7'h00;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.spark_q <= `IGC_SPARK_RESET;
      st_q.dac_q <= `IGC_DAC_RESET;
      st_q.mode_q <= `IGC_MODE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest = req && !st_q.ack_q;
  assign avs_readdata = st_q.rdata_q;
  assign gate_drive_out = st_q.gate_on_q;
  assign low_clamp_out = st_q.clamp_q;
  assign spark_length_out = st_q.spark_len_q;
  assign end_spark_sel_out = st_q.spark_q[`IGC_B_END_LO +: 2];
  assign gain_two_out = st_q.spark_q[`IGC_B_GAIN];
  assign max_current_offset_out = st_q.offset_pct_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence os_trip_s;
    ign && clamp_en && os_exp && !gate_rise;
  endsequence

  sequence soft_cause_s;
    ign && gentle_en && st_q.gate_on_q && (off_lvl || ov_lvl);
  endsequence

  spark_rise_a: assert property (ign && fb_hi |=> spark_length_out)
    else $error("spark length did not rise");
  spark_fall_a: assert property (ign && !fb_hi && fb_lo |=> !spark_length_out)
    else $error("spark length did not fall");
  os_clamp_a: assert property (os_trip_s |=> low_clamp_out)
    else $error("open secondary did not clamp");
  gentle_off_a: assert property (soft_cause_s |=> low_clamp_out && !gate_drive_out)
    else $error("gentle off did not clamp");
  dwell_off_a: assert property (dwell_trip |=> !gate_drive_out ##1 !gate_drive_out)
    else $error("dwell limit left gate on");
  dwell_hidden_a: assert property (!dwell_en |-> !dwell_fault_vis)
    else $error("dwell fault visible while disabled");
  dwell_noclamp_a: assert property (!dwell_en && !gentle_en && !clamp_en
                                    && !$past(gentle_en) |=> !low_clamp_out)
    else $error("clamp without a cause");
  general_mode_a: assert property (!ign |=> !low_clamp_out && !spark_length_out)
    else $error("ignition feature in general mode");
  toggle_only_a: assert property (st_q.off_latched_q && gate_lvl |=> !gate_drive_out)
    else $error("gate returned without toggle");
  overlap_raise_a: assert property (ign && st_q.mode_q[1] && other_on && st_q.gate_on_q
                   |=> max_current_offset_out == overlap_pct($past(st_q.dac_q[7:5])))
    else $error("overlap raise wrong");
  dwell_clear_a: assert property (!gate_lvl |=> !dwell_exp)
    else $error("dwell timer not cleared");

  // Further guards: pins, timers, latches and the bus answer
  sequence pin_off_s;
    off_lvl || ov_lvl;
  endsequence

  sequence latch_free_s;
    !gate_lvl && !dwell_trip;
  endsequence

  pin_off_a: assert property (pin_off_s |=> !gate_drive_out)
    else $error("gate on while outputs are disabled");

  gate_follow_a: assert property (!ign && !off_lvl && !ov_lvl
                                  |=> gate_drive_out == $past(gate_lvl))
    else $error("general mode gate does not follow input");

  os_clear_a: assert property (!prim_hi |=> !os_exp)
    else $error("open secondary timer not cleared");

  os_hold_a: assert property (ign && st_q.os_fault_q && !gate_rise |=> st_q.os_fault_q)
    else $error("open secondary fault lost");

  latch_free_a: assert property (latch_free_s |=> !st_q.off_latched_q)
    else $error("shutdown latch kept with gate input low");

  overlap_off_a: assert property (!st_q.mode_q[`IGC_B_OVL_EN]
                                  |=> max_current_offset_out == 7'h00)
    else $error("overlap raise while compensation is off");

  overlap_range_a: assert property (max_current_offset_out <= 7'h50)
    else $error("overlap raise above range");

  dwell_long_a: assert property (st_q.spark_q[`IGC_B_DWELL_LO +: 3] > 3'h4
                                 |-> dwell_limit == DWELL_64_CYC)
    else $error("long dwell code not at longest limit");

  bus_wait_a: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
endmodule : igc_top

// file: bench/igc_ecu_model.sv
// Engine controller model: drives the gate and comparator pins, times the spark length.
// Assumes mclk from the bench; every pin changes just after a rising edge.
`timescale 1ns/1ps
module igc_ecu_model (
  input wire logic mclk, // System clock
  input wire logic spark_length_out, // Spark length from the block
  output logic gate, // Gate input pin
  output logic fb_hi, // Feedback above begin threshold
  output logic fb_lo, // Feedback below end threshold
  output logic primary // Primary above 135 V
);
  int width;
  int run;

  initial begin
    gate = 1'b0;
    fb_hi = 1'b0;
    fb_lo = 1'b1;
    primary = 1'b0;
    width = 0;
    run = 0;
  end

  // Input capture of the spark length in cycles
  always @(posedge mclk) begin
    run <= spark_length_out ? run + 1 : 0;
    if (!spark_length_out && run != 0) begin
      width <= run;
    end
  end

  // Collector passes both thresholds up, falls below the begin one 2 cycles later and below the end one w cycles later
  task automatic spark(input int w);
    fb_hi <= 1'b1;
    fb_lo <= 1'b0;
    repeat (2) @(posedge mclk);
    fb_hi <= 1'b0;
    repeat (w - 2) @(posedge mclk);
    fb_lo <= 1'b1;
    @(posedge mclk);
  endtask : spark

  // Re-arm a channel after a shutdown; ends with the gate input high
  task automatic retoggle();
    gate <= 1'b0;
    repeat (4) @(posedge mclk);
    gate <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : retoggle
endmodule : igc_ecu_model

// file: bench/ignition_gate_control_test.sv
// Self-checking bench of the ignition gate control block with a controller model.
// Assumes shortened timer parameters; all drives change right after a rising edge.
`timescale 1ns/1ps
`include "igc_defines.svh"
module ignition_gate_control_test;
  localparam int OS_LIM [4] = '{2000, 4000, 40, 80};
  localparam int DW_LIM [8] = '{200, 300, 400, 500, 600, 700, 700, 700};
  localparam logic [6:0] OVL_PCT [8] = '{7'h00, 7'h07, 7'h0F, 7'h18, 7'h23, 7'h2F, 7'h3F, 7'h50};
  logic mclk;
  logic rst_n;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic outputs_off_in, overvoltage_in, other_dwell_in;
  logic gate_control_in, fb_hi, fb_lo, primary_high_in;
  logic gate_drive_out, low_clamp_out, spark_length_out, gain_two_out;
  logic [1:0] end_spark_sel_out;
  logic [6:0] max_current_offset_out;
  logic [31:0] rd;
  int fail_count;
  int num_checks;

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  igc_top #(
    .OS_50_CYC(24'(OS_LIM[2])), .OS_100_CYC(24'(OS_LIM[3])),
    .DWELL_2_CYC(24'(DW_LIM[0])), .DWELL_4_CYC(24'(DW_LIM[1])),
    .DWELL_8_CYC(24'(DW_LIM[2])), .DWELL_16_CYC(24'(DW_LIM[3])),
    .DWELL_32_CYC(24'(DW_LIM[4])), .DWELL_64_CYC(24'(DW_LIM[5]))
  ) dut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .gate_control_in(gate_control_in), .outputs_off_in(outputs_off_in),
    .overvoltage_in(overvoltage_in), .collector_feedback_hi_in(fb_hi),
    .collector_feedback_lo_in(fb_lo), .primary_high_in(primary_high_in),
    .other_dwell_in(other_dwell_in), .gate_drive_out(gate_drive_out),
    .low_clamp_out(low_clamp_out), .spark_length_out(spark_length_out),
    .end_spark_sel_out(end_spark_sel_out), .gain_two_out(gain_two_out),
    .max_current_offset_out(max_current_offset_out)
  );

  igc_ecu_model ecu (
    .mclk(mclk), .spark_length_out(spark_length_out), .gate(gate_control_in),
    .fb_hi(fb_hi), .fb_lo(fb_lo), .primary(primary_high_in)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // One Avalon-MM transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= 4'h3;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    check({31'h0, avs_waitrequest}, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  function automatic logic [31:0] spk(input logic [2:0] dw, input logic en,
      input logic gentle, input logic clamp, input logic [1:0] os, input logic [1:0] es);
    return {20'h00000, dw, en, 2'h0, gentle, clamp, os, es};
  endfunction : spk

  task automatic t_regs();
    check({end_spark_sel_out, gain_two_out}, 3'h2);
    bus(1'b0, `IGC_REG_SPARK, 32'h0);
    check(rd, 32'h0000090D);
    bus(1'b0, `IGC_REG_DAC, 32'h0);
    check(rd, 32'h00000080);
    bus(1'b1, `IGC_REG_STATUS, 32'h0000FFFF);
    bus(1'b0, `IGC_REG_STATUS, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 4'h2, 32'h0000FFFF);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `IGC_REG_SPARK, 32'(k) | (k[0] ? 32'h40 : 32'h0));
      check({end_spark_sel_out, gain_two_out}, {k[1:0], k[0]});
    end
  endtask : t_regs

  task automatic t_opensec();
    for (int k = 0; k < 5; k++) begin
      logic [1:0] os;
      os = k < 4 ? 2'(k) : 2'h3;
      bus(1'b1, `IGC_REG_SPARK, spk(3'h0, 1'b0, 1'b0, k < 4, os, 2'h1));
      ecu.primary <= 1'b1;
      tick(OS_LIM[os] - 10);
      check(low_clamp_out, 1'b0);
      tick(30);
      check(low_clamp_out, k < 4);
      bus(1'b0, `IGC_REG_STATUS, 32'h0);
      check(rd[4], 1'b1);
      ecu.primary <= 1'b0;
      ecu.retoggle();
      ecu.gate <= 1'b0;
      tick(5);
    end
  endtask : t_opensec

  task automatic t_dwell();
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, `IGC_REG_SPARK, spk(3'(k), 1'b1, k != 7, 1'b1, 2'h3, 2'h1));
      ecu.gate <= 1'b1;
      tick(DW_LIM[k] - 10);
      check({gate_drive_out, low_clamp_out}, 2'h2);
      tick(20);
      check({gate_drive_out, low_clamp_out}, {1'b0, k != 7});
      if (k == 0) begin
        bus(1'b0, `IGC_REG_STATUS, 32'h0);
        check(rd[5], 1'b1);
        check(gate_drive_out, 1'b0);
        bus(1'b1, `IGC_REG_SPARK, spk(3'h0, 1'b0, 1'b1, 1'b1, 2'h3, 2'h1));
        bus(1'b0, `IGC_REG_STATUS, 32'h0);
        check(rd[5], 1'b0);
        ecu.retoggle();
        tick(3);
        check(gate_drive_out, 1'b1);
      end
      ecu.gate <= 1'b0;
      tick(5);
    end
    bus(1'b1, `IGC_REG_SPARK, spk(3'h0, 1'b0, 1'b1, 1'b1, 2'h3, 2'h1));
    ecu.gate <= 1'b1;
    tick(250);
    check({gate_drive_out, low_clamp_out}, 2'h2);
    bus(1'b0, `IGC_REG_STATUS, 32'h0);
    check(rd[5], 1'b0);
    ecu.gate <= 1'b0;
    bus(1'b1, `IGC_REG_SPARK, spk(3'h0, 1'b1, 1'b0, 1'b1, 2'h3, 2'h1));
    ecu.gate <= 1'b1;
    tick(150);
    ecu.gate <= 1'b0;
    tick(5);
    ecu.gate <= 1'b1;
    tick(150);
    check(gate_drive_out, 1'b1);
    ecu.gate <= 1'b0;
    tick(5);
  endtask : t_dwell

  task automatic t_gentle();
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `IGC_REG_SPARK, spk(3'h0, 1'b0, k < 2, 1'b1, 2'h3, 2'h1));
      ecu.gate <= 1'b1;
      tick(10);
      if (k == 1) overvoltage_in <= 1'b1;
      else outputs_off_in <= 1'b1;
      tick(6);
      check({gate_drive_out, low_clamp_out}, {1'b0, k < 2});
      outputs_off_in <= 1'b0;
      overvoltage_in <= 1'b0;
      ecu.gate <= 1'b0;
      tick(6);
    end
  endtask : t_gentle

  task automatic t_overlap();
    bus(1'b1, `IGC_REG_MODE, 32'h2);
    other_dwell_in <= 1'b1;
    ecu.gate <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, `IGC_REG_DAC, 32'(k) << 5);
      tick(5);
      check(max_current_offset_out, OVL_PCT[k]);
    end
    other_dwell_in <= 1'b0;
    tick(6);
    check(max_current_offset_out, 7'h00);
    ecu.gate <= 1'b0;
    tick(5);
  endtask : t_overlap

  task automatic t_spark();
    ecu.spark(12);
    tick(5);
    check(ecu.width, 32'h0000000C);
    bus(1'b1, `IGC_REG_MODE, 32'h1);
    bus(1'b1, `IGC_REG_SPARK, spk(3'h0, 1'b1, 1'b1, 1'b1, 2'h3, 2'h1));
    ecu.width <= 0;
    ecu.gate <= 1'b1;
    ecu.spark(12);
    tick(250);
    check({gate_drive_out, low_clamp_out}, 2'h2);
    check(ecu.width, 32'h0);
    ecu.gate <= 1'b0;
    bus(1'b1, `IGC_REG_MODE, 32'h0);
  endtask : t_spark

  initial begin
    tick(40000);
    fail_count++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    outputs_off_in = 1'b0;
    overvoltage_in = 1'b0;
    other_dwell_in = 1'b0;
    fail_count = 0;
    num_checks = 0;
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    t_regs();
    $display("registers done");
    t_opensec();
    $display("open secondary done");
    t_dwell();
    $display("dwell limit done");
    t_gentle();
    $display("gentle off done");
    t_overlap();
    $display("overlap done");
    t_spark();
    $display("spark length done");
    stop_test();
  end
endmodule : ignition_gate_control_test
